// [rtl/conv_pkg.sv]
// Purpose: Shared constants, register map and helpers for the input conversion block
// Assumes: AXI4-Lite with 32-bit data, one aligned word per register
// Notes:   Printed offsets are register indices; the byte address is four times the index
package conv_pkg;

  // Register indices and byte addresses
  localparam logic [7:0]  IDX_INPUT_CONV_MODE   = 8'h0E;
  localparam logic [7:0]  IDX_IMAGE_SIZE        = 8'h10;
  localparam logic [7:0]  IDX_TRANSFER_MODE     = 8'h11;
  localparam logic [7:0]  IDX_PIXELS_LEFT       = 8'h12;
  localparam logic [7:0]  ADDR_INPUT_CONV_MODE  = {IDX_INPUT_CONV_MODE[5:0], 2'b00};
  localparam logic [7:0]  ADDR_IMAGE_SIZE       = {IDX_IMAGE_SIZE[5:0], 2'b00};
  localparam logic [7:0]  ADDR_TRANSFER_MODE    = {IDX_TRANSFER_MODE[5:0], 2'b00};
  localparam logic [7:0]  ADDR_PIXELS_LEFT      = {IDX_PIXELS_LEFT[5:0], 2'b00};

  // Field positions in the input conversion mode and image size registers
  localparam int          MODE_B2_POS           = 4;
  localparam int          MEM_SWAP_POS          = 3;
  localparam int          PORT_SWAP_POS         = 2;
  localparam int          MODE_B1_POS           = 1;
  localparam int          MODE_B0_POS           = 0;
  localparam int          HEIGHT_POS            = 16;

  // Values after reset
  localparam logic [2:0]  MODE_RESET            = 3'h0;
  localparam logic        SWAP_RESET            = 1'b0;
  localparam logic [15:0] SIZE_RESET            = 16'h0000;
  localparam logic [1:0]  XFER_RESET            = 2'h0;
  localparam logic [31:0] PIXELS_RESET          = 32'h0000_0000;

  // Colour conversion modes, {b2, b1, b0}
  localparam logic [2:0]  MODE_NORMAL           = 3'h0;
  localparam logic [2:0]  MODE_YUV              = 3'h1;
  localparam logic [2:0]  MODE_DELTA_YUV        = 3'h2;
  localparam logic [2:0]  MODE_RAW16            = 3'h3;
  localparam logic [2:0]  MODE_RAW8             = 3'h7;

  // Transfer mode codes
  localparam logic [1:0]  XFER_MODE_00          = 2'h0;
  localparam logic [1:0]  XFER_MODE_01          = 2'h1;
  localparam logic [1:0]  XFER_MODE_11          = 2'h3;

  // Bus responses and data path sizes
  localparam logic [1:0]  RESP_OKAY             = 2'h0;
  localparam logic [1:0]  RESP_SLVERR           = 2'h2;
  localparam int          ENTRY_FIFO_DEPTH      = 8;
  localparam int          PIXEL_WIDTH           = 16;

  function automatic logic [15:0] swap16(input logic [15:0] d);
    swap16 = {d[7:0], d[15:8]};
  endfunction : swap16

  function automatic logic port_mode_active(input logic [2:0] m);
    port_mode_active = (m == MODE_YUV) || (m == MODE_DELTA_YUV) || (m == MODE_RAW16) || (m == MODE_RAW8);
  endfunction : port_mode_active

  function automatic logic mem_swap_valid(input logic [2:0] m, input logic [1:0] x);
    mem_swap_valid = (m == MODE_NORMAL) && ((x == XFER_MODE_00) || (x == XFER_MODE_01));
  endfunction : mem_swap_valid

  function automatic logic port_swap_valid(input logic [2:0] m, input logic [1:0] x);
    port_swap_valid = port_mode_active(m) && ((x == XFER_MODE_00) || (x == XFER_MODE_11));
  endfunction : port_swap_valid

  function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    apply_strb = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        apply_strb[8*i +: 8] = new_v[8*i +: 8];
      end
    end
  endfunction : apply_strb

endpackage : conv_pkg

// [rtl/entry_fifo.sv]
// Purpose: Small synchronous FIFO with valid and ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Full and empty come straight from the occupancy count
`timescale 1ns/1ns
module entry_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  import conv_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [CW-1:0]               count;
  } fifo_state_t;

  fifo_state_t state_reg;
  fifo_state_t state_next;
  logic        push;
  logic        pop;

  assign o_in_ready  = (state_reg.count != FULL_COUNT);
  assign o_out_valid = (state_reg.count != '0);
  assign o_out_data  = state_reg.mem[state_reg.rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wr_ptr] = i_in_data;
      state_next.wr_ptr = state_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      state_next.rd_ptr = state_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      state_next.count = state_reg.count + 1'b1;
    end else if (pop && !push) begin
      state_next.count = state_reg.count - 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : entry_fifo

// [rtl/axil_slave.sv]
// Purpose: AXI4-Lite slave front end turning bus beats into register strobes
// Assumes: One write and one read outstanding at most
// Notes:   Address and data may arrive in either order; reads have no side effects
`timescale 1ns/1ns
module axil_slave (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic             o_reg_wr,
  output logic [7:0]       o_reg_wr_addr,
  output logic [31:0]      o_reg_wr_data,
  output logic [3:0]       o_reg_wr_strb,
  input  wire logic        i_reg_wr_hit,
  output logic [7:0]       o_reg_rd_addr,
  input  wire logic [31:0] i_reg_rd_data,
  input  wire logic        i_reg_rd_hit
);
  import conv_pkg::*;

  typedef struct packed {
    logic        aw_have;
    logic [7:0]  awaddr;
    logic        w_have;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_state_t;

  axil_state_t state_reg;
  axil_state_t state_next;

  assign o_awready     = !state_reg.aw_have && !state_reg.bvalid;
  assign o_wready      = !state_reg.w_have && !state_reg.bvalid;
  assign o_arready     = !state_reg.rvalid;
  assign o_bvalid      = state_reg.bvalid;
  assign o_bresp       = state_reg.bresp;
  assign o_rvalid      = state_reg.rvalid;
  assign o_rdata       = state_reg.rdata;
  assign o_rresp       = state_reg.rresp;
  // Write fires only once both halves are held, so a lone beat never commits
  assign o_reg_wr      = state_reg.aw_have && state_reg.w_have && !state_reg.bvalid;
  assign o_reg_wr_addr = state_reg.awaddr;
  assign o_reg_wr_data = state_reg.wdata;
  assign o_reg_wr_strb = state_reg.wstrb;
  assign o_reg_rd_addr = i_araddr;

  always_comb begin
    state_next = state_reg;
    if (i_awvalid && o_awready) begin
      state_next.aw_have = 1'b1;
      state_next.awaddr  = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      state_next.w_have = 1'b1;
      state_next.wdata  = i_wdata;
      state_next.wstrb  = i_wstrb;
    end
    if (o_reg_wr) begin
      state_next.aw_have = 1'b0;
      state_next.w_have  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = i_reg_wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (state_reg.bvalid && i_bready) begin
      state_next.bvalid = 1'b0;
    end
    if (i_arvalid && o_arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = i_reg_rd_hit ? i_reg_rd_data : 32'h0000_0000;
      state_next.rresp  = i_reg_rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (state_reg.rvalid && i_rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : axil_slave

// [rtl/input_data_conversion_mode.sv]
// Purpose: Input conversion mode register and host-to-memory byte-swap paths
// Assumes: All inputs come from logic on i_clk; the colour converter sits downstream
// Notes:   Entry port words are swapped before they enter the FIFO
//
// Function
// R1 - Software writes zero to reserved bits 15 to 5 of the mode register.
// R2 - Three-bit colour mode at bits 4, 1, 0 selects conversion to RGB.
// R3 - Memory swap bit set exchanges bytes of word-access host memory writes.
// R4 - Memory swap only when mode is 000 and transfer mode is 00 or 01.
// R5 - Memory swap never applies to register writes or memory reads.
// R6 - Port swap only for entry port data, modes 001/010/011/111, transfer 00/11.
// R7 - Port swap bit set exchanges bytes of each 16-bit entry port word.
// R8 - Port swap bit clear passes entry port words unchanged.
// R9 - Mode and swap bits are host readable, writable, and start at zero.
// R10 - Reset clears every bit of the mode register.
// R11 - Mode 000 normal, 001 YUV, 010 delta-YUV, 011 raw16, 111 raw8.
// R12 - Pixel total of width times height counts down; zero returns mode to normal.
// R13 - Software never programs mode codes 101 or 110.
// R14 - A swap bit outside its valid combination acts as zero.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ns
module input_data_conversion_mode (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_mem_wr_valid,
  input  wire logic        i_mem_wr_word,
  input  wire logic [15:0] i_mem_wr_data,
  output logic             o_mem_wr_valid,
  output logic [15:0]      o_mem_wr_data,
  input  wire logic        i_mem_rd_valid,
  input  wire logic [15:0] i_mem_rd_data,
  output logic             o_host_rd_valid,
  output logic [15:0]      o_host_rd_data,
  input  wire logic        i_entry_valid,
  input  wire logic [15:0] i_entry_data,
  output logic             o_entry_ready,
  output logic             o_pix_valid,
  output logic [15:0]      o_pix_data,
  input  wire logic        i_pix_ready,
  output logic [2:0]       o_conv_mode,
  output logic [1:0]       o_transfer_mode
);
  import conv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [2:0]  conv_mode;
    logic        memory_byte_swap;
    logic        port_byte_swap;
    logic [1:0]  transfer_mode;
    logic [15:0] image_width_count;
    logic [15:0] image_height_count;
    logic [31:0] pixels_left;
    logic        mem_wr_valid;
    logic [15:0] mem_wr_data;
    logic        host_rd_valid;
    logic [15:0] host_rd_data;
  } conv_state_t;

  conv_state_t state_reg;
  conv_state_t state_next;

  logic        reg_wr;
  logic [7:0]  reg_wr_addr;
  logic [31:0] reg_wr_data;
  logic [3:0]  reg_wr_strb;
  logic        reg_wr_hit;
  logic [7:0]  reg_rd_addr;
  logic [31:0] reg_rd_data;
  logic        reg_rd_hit;
  logic [31:0] mode_word;
  logic [31:0] mode_word_new;
  logic [31:0] size_word;
  logic [31:0] size_word_new;
  logic [31:0] xfer_word_new;
  logic        mem_swap_eff;
  logic        port_swap_eff;
  logic        fifo_in_ready;
  logic        entry_fire;
  logic [15:0] entry_word;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == ADDR_INPUT_CONV_MODE) || (a == ADDR_IMAGE_SIZE) ||
               (a == ADDR_TRANSFER_MODE) || (a == ADDR_PIXELS_LEFT);
  endfunction : addr_hit

  ////////////////////////////////////////////////////////////////////////////
  // Register bus

  axil_slave u_axil (
    .i_clk         (i_clk),
    .i_rst_n       (i_rst_n),
    .i_awaddr      (i_awaddr),
    .i_awvalid     (i_awvalid),
    .o_awready     (o_awready),
    .i_wdata       (i_wdata),
    .i_wstrb       (i_wstrb),
    .i_wvalid      (i_wvalid),
    .o_wready      (o_wready),
    .o_bresp       (o_bresp),
    .o_bvalid      (o_bvalid),
    .i_bready      (i_bready),
    .i_araddr      (i_araddr),
    .i_arvalid     (i_arvalid),
    .o_arready     (o_arready),
    .o_rdata       (o_rdata),
    .o_rresp       (o_rresp),
    .o_rvalid      (o_rvalid),
    .i_rready      (i_rready),
    .o_reg_wr      (reg_wr),
    .o_reg_wr_addr (reg_wr_addr),
    .o_reg_wr_data (reg_wr_data),
    .o_reg_wr_strb (reg_wr_strb),
    .i_reg_wr_hit  (reg_wr_hit),
    .o_reg_rd_addr (reg_rd_addr),
    .i_reg_rd_data (reg_rd_data),
    .i_reg_rd_hit  (reg_rd_hit)
  );

  assign reg_wr_hit = addr_hit(reg_wr_addr);
  assign reg_rd_hit = addr_hit(reg_rd_addr);

  // R9 mode bits readable
  always_comb begin
    mode_word = 32'h0000_0000;
    mode_word[MODE_B2_POS]   = state_reg.conv_mode[2];
    mode_word[MEM_SWAP_POS]  = state_reg.memory_byte_swap;
    mode_word[PORT_SWAP_POS] = state_reg.port_byte_swap;
    mode_word[MODE_B1_POS]   = state_reg.conv_mode[1];
    mode_word[MODE_B0_POS]   = state_reg.conv_mode[0];
  end

  assign size_word     = {state_reg.image_height_count, state_reg.image_width_count};
  assign mode_word_new = apply_strb(mode_word, reg_wr_data, reg_wr_strb);
  assign size_word_new = apply_strb(size_word, reg_wr_data, reg_wr_strb);
  assign xfer_word_new = apply_strb({30'h0000_0000, state_reg.transfer_mode}, reg_wr_data, reg_wr_strb);

  // Reserved bits read as zero
  always_comb begin
    case (reg_rd_addr)
      ADDR_INPUT_CONV_MODE: reg_rd_data = mode_word;
      ADDR_IMAGE_SIZE:      reg_rd_data = size_word;
      ADDR_TRANSFER_MODE:   reg_rd_data = {30'h0000_0000, state_reg.transfer_mode};
      ADDR_PIXELS_LEFT:     reg_rd_data = state_reg.pixels_left;
      default:              reg_rd_data = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Swap qualification

  // R4 memory swap gating
  // R14 invalid means zero
  assign mem_swap_eff  = state_reg.memory_byte_swap && mem_swap_valid(state_reg.conv_mode, state_reg.transfer_mode);
  // R6 port swap gating
  // R14 invalid means zero
  assign port_swap_eff = state_reg.port_byte_swap && port_swap_valid(state_reg.conv_mode, state_reg.transfer_mode);

  ////////////////////////////////////////////////////////////////////////////
  // Entry port path

  // R11 normal mode refuses
  // R13 prohibited codes refused
  assign o_entry_ready = port_mode_active(state_reg.conv_mode) && (state_reg.pixels_left != PIXELS_RESET) &&
                         fifo_in_ready;
  assign entry_fire    = i_entry_valid && o_entry_ready;
  // R7 port byte swap
  // R8 unchanged when clear
  assign entry_word    = port_swap_eff ? swap16(i_entry_data) : i_entry_data;

  // Buffer lets the converter stall without dropping words already counted
  entry_fifo #(
    .WIDTH (PIXEL_WIDTH),
    .DEPTH (ENTRY_FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (entry_fire),
    .i_in_data   (entry_word),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (o_pix_valid),
    .o_out_data  (o_pix_data),
    .i_out_ready (i_pix_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    state_next = state_reg;

    // R3 memory byte swap
    // R5 only word memory writes
    state_next.mem_wr_valid = i_mem_wr_valid;
    if (i_mem_wr_valid) begin
      state_next.mem_wr_data = (i_mem_wr_word && mem_swap_eff) ? swap16(i_mem_wr_data) : i_mem_wr_data;
    end
    // R5 reads never swapped
    state_next.host_rd_valid = i_mem_rd_valid;
    if (i_mem_rd_valid) begin
      state_next.host_rd_data = i_mem_rd_data;
    end

    // R12 count processed pixels
    if (entry_fire) begin
      state_next.pixels_left = state_reg.pixels_left - 32'h0000_0001;
    end
    // R12 exhausted returns normal
    if (port_mode_active(state_reg.conv_mode) && (state_reg.pixels_left == PIXELS_RESET)) begin
      state_next.conv_mode = MODE_NORMAL;
    end

    // Software write wins over the automatic return to normal
    if (reg_wr) begin
      case (reg_wr_addr)
        ADDR_INPUT_CONV_MODE: begin
          // R2 mode field placement
          // R1 reserved bits dropped
          state_next.conv_mode        = {mode_word_new[MODE_B2_POS], mode_word_new[MODE_B1_POS],
                                         mode_word_new[MODE_B0_POS]};
          state_next.memory_byte_swap = mode_word_new[MEM_SWAP_POS];
          state_next.port_byte_swap   = mode_word_new[PORT_SWAP_POS];
          // R12 load pixel total
          state_next.pixels_left      = 32'(state_reg.image_width_count) * 32'(state_reg.image_height_count);
        end
        ADDR_IMAGE_SIZE: begin
          state_next.image_width_count  = size_word_new[HEIGHT_POS-1:0];
          state_next.image_height_count = size_word_new[31:HEIGHT_POS];
        end
        ADDR_TRANSFER_MODE: begin
          state_next.transfer_mode = xfer_word_new[1:0];
        end
        default: begin
          state_next.transfer_mode = state_next.transfer_mode;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      // R10 reset clears mode
      // R9 initial zero
      state_reg.conv_mode          <= MODE_RESET;
      state_reg.memory_byte_swap   <= SWAP_RESET;
      state_reg.port_byte_swap     <= SWAP_RESET;
      state_reg.transfer_mode      <= XFER_RESET;
      state_reg.image_width_count  <= SIZE_RESET;
      state_reg.image_height_count <= SIZE_RESET;
      state_reg.pixels_left        <= PIXELS_RESET;
      state_reg.mem_wr_valid       <= 1'b0;
      state_reg.mem_wr_data        <= 16'h0000;
      state_reg.host_rd_valid      <= 1'b0;
      state_reg.host_rd_data       <= 16'h0000;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_mem_wr_valid  = state_reg.mem_wr_valid;
  assign o_mem_wr_data   = state_reg.mem_wr_data;
  assign o_host_rd_valid = state_reg.host_rd_valid;
  assign o_host_rd_data  = state_reg.host_rd_data;
  assign o_conv_mode     = state_reg.conv_mode;
  assign o_transfer_mode = state_reg.transfer_mode;

endmodule : input_data_conversion_mode

// [tb/entry_src.sv]
// Purpose: Host side source of words for the image entry port
// Assumes: Words are numbered from reset, C3 in the upper byte
// Notes:   Idle data is inverted so a stale word never looks valid
`timescale 1ns/1ns
module entry_src (
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_run,
  input  wire logic        i_ready,
  output logic             o_valid,
  output logic [15:0]      o_data
);
  logic [7:0] cnt_reg;
  assign o_valid = i_run;
  assign o_data  = {8'hC3, cnt_reg} ^ {16{!i_run}};
  // Word held until taken
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) cnt_reg <= 8'h00;
    else if (i_run && i_ready) cnt_reg <= cnt_reg + 8'h01;
  end
endmodule : entry_src

// [tb/input_data_conversion_mode_chk.sv]
// Purpose: Port level checks of the input conversion block
// Assumes: Bench never writes the mode register during a memory cycle
// Notes:   Bound to every instance of the top module
`timescale 1ns/1ns
module input_data_conversion_mode_chk (
  input wire logic        i_clk,
  input wire logic        i_rst_n,
  input wire logic        i_mem_wr_valid,
  input wire logic        i_mem_wr_word,
  input wire logic [15:0] i_mem_wr_data,
  input wire logic        o_mem_wr_valid,
  input wire logic [15:0] o_mem_wr_data,
  input wire logic        i_mem_rd_valid,
  input wire logic [15:0] i_mem_rd_data,
  input wire logic        o_host_rd_valid,
  input wire logic [15:0] o_host_rd_data,
  input wire logic [2:0]  o_conv_mode,
  input wire logic [1:0]  o_transfer_mode,
  input wire logic        o_entry_ready,
  input wire logic        o_pix_valid,
  input wire logic [15:0] o_pix_data,
  input wire logic        i_pix_ready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic        o_rvalid
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  chk_mem_timing: assert property (o_mem_wr_valid == $past(i_mem_wr_valid))
    else $error("write strobe late");
  chk_mem_ignore: assert property (i_mem_wr_valid && (o_conv_mode != 3'h0 || !i_mem_wr_word
    || o_transfer_mode[1]) |=> o_mem_wr_data == $past(i_mem_wr_data)) else $error("memory word swapped");
  chk_host_rd: assert property (i_mem_rd_valid |=> o_host_rd_valid
    && o_host_rd_data == $past(i_mem_rd_data)) else $error("memory read altered");
  chk_port_gate: assert property (!(o_conv_mode inside {3'h1, 3'h2, 3'h3, 3'h7}) |-> !o_entry_ready)
    else $error("entry port open");
  chk_pix_hold: assert property (o_pix_valid && !i_pix_ready |=> o_pix_valid && $stable(o_pix_data))
    else $error("stalled word changed");
  chk_rd_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read answer late");
  chk_reset_mode: assert property (disable iff (1'b0) !i_rst_n |=> o_conv_mode == 3'h0 && !o_pix_valid)
    else $error("mode kept by reset");
  chk_reset_xfer: assert property (disable iff (1'b0) !i_rst_n |=> o_transfer_mode == 2'h0 && !o_entry_ready)
    else $error("transfer mode kept");
endmodule : input_data_conversion_mode_chk
bind input_data_conversion_mode input_data_conversion_mode_chk u_chk (.*);

// [tb/input_data_conversion_mode_tb.sv]
// Purpose: Self-checking bench for the input conversion block
// Assumes: Bus answers are sampled at the falling edge
// Notes:   Reserved mode bits and codes 101 and 110 are never written
`timescale 1ns/1ns
module input_data_conversion_mode_tb;
  import conv_pkg::*;
  typedef struct packed {logic [7:0] mode; logic [1:0] xfer; logic word; logic sw;} row_t;
  logic        i_clk, i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, run, i_pix_ready;
  logic        i_mem_wr_valid, i_mem_wr_word, i_mem_rd_valid, i_entry_valid, o_awready, o_wready, o_bvalid;
  logic        o_arready, o_rvalid, o_mem_wr_valid, o_host_rd_valid, o_entry_ready, o_pix_valid;
  logic [7:0]  i_awaddr, i_araddr;
  logic [3:0]  i_wstrb;
  logic [31:0] i_wdata, o_rdata, rd_val;
  logic [15:0] i_mem_wr_data, i_mem_rd_data, i_entry_data, o_mem_wr_data, o_host_rd_data, o_pix_data;
  logic [1:0]  o_bresp, o_rresp, o_transfer_mode, resp;
  logic [2:0]  o_conv_mode;
  int          errors, comparisons, k, n;
  // Rows packed as {mode byte, transfer mode, word access, swap expected}
  row_t        rows [7] = '{12'h083, 12'h087, 12'h08E, 12'h002, 12'h080, 12'h042, 12'h092};
  row_t        prow [5] = '{12'h051, 12'h061, 12'h07D, 12'h171, 12'h074};
  input_data_conversion_mode dut (.*);
  entry_src src (.i_clk, .i_rst_n, .i_run(run), .i_ready(o_entry_ready), .o_valid(i_entry_valid),
    .o_data(i_entry_data));
  ////////////////////////////////////////
  task automatic test_done();
    $display("Counts: %0d errors, %0d comparisons", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic guard(input logic ok);
    if (!ok) begin
      errors++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      test_done();
    end
  endtask : guard
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    n = 0;
    @(posedge i_clk);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = i_awvalid && o_awready;
      tw = i_wvalid && o_wready;
      tb = o_bvalid;
      resp = o_bresp;
      @(posedge i_clk);
      if (ta) i_awvalid <= 1'b0;
      if (tw) i_wvalid <= 1'b0;
      n++;
    end while (!tb && n < 40);
    i_bready <= 1'b0;
    guard(tb);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    n = 0;
    @(posedge i_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(negedge i_clk);
      ta = i_arvalid && o_arready;
      tr = o_rvalid;
      rd_val = o_rdata;
      resp = o_rresp;
      @(posedge i_clk);
      if (ta) i_arvalid <= 1'b0;
      n++;
    end while (!tr && n < 40);
    i_rready <= 1'b0;
    guard(tr);
  endtask : rd
  task automatic drain(input int cnt, input logic sw);
    logic [15:0] e;
    n = 0;
    @(posedge i_clk);
    i_pix_ready <= 1'b1;
    while (cnt > 0 && n < 60) begin
      @(negedge i_clk);
      n++;
      e = {8'hC3, k[7:0]};
      if (o_pix_valid) begin
        check(o_pix_data, sw ? {e[7:0], e[15:8]} : e);
        k++;
        cnt--;
      end
    end
    @(posedge i_clk);
    i_pix_ready <= 1'b0;
    guard(cnt == 0);
  endtask : drain
  ////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  initial begin
    {i_rst_n, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, run, i_pix_ready} = 8'h00;
    {i_mem_wr_valid, i_mem_wr_word, i_mem_rd_valid, i_awaddr, i_araddr, i_wdata} = 51'h0;
    {i_mem_wr_data, i_mem_rd_data} = 32'h0;
    i_wstrb = 4'hF;
    {errors, comparisons, k} = '0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(ADDR_INPUT_CONV_MODE);
    check(rd_val, 32'h0);
    rd(8'hFC);
    check(resp, RESP_SLVERR);
    wr(ADDR_IMAGE_SIZE, 32'h0001_0004);
    check(resp, RESP_OKAY);
    foreach (rows[i]) begin
      wr(ADDR_TRANSFER_MODE, {30'h0, rows[i].xfer});
      wr(ADDR_INPUT_CONV_MODE, {24'h0, rows[i].mode});
      rd(ADDR_INPUT_CONV_MODE);
      check(rd_val, {24'h0, rows[i].mode});
      check(o_conv_mode, {rows[i].mode[4], rows[i].mode[1:0]});
      @(posedge i_clk);
      {i_mem_wr_valid, i_mem_wr_word, i_mem_wr_data} <= {1'b1, rows[i].word, 16'h12AB};
      {i_mem_rd_valid, i_mem_rd_data} <= {1'b1, 16'h12AB};
      @(posedge i_clk);
      {i_mem_wr_valid, i_mem_rd_valid} <= 2'b00;
      @(negedge i_clk);
      check(o_mem_wr_data, rows[i].sw ? 16'hAB12 : 16'h12AB);
      check(o_host_rd_data, 16'h12AB);
    end
    wr(ADDR_TRANSFER_MODE, 32'h0);
    wr(ADDR_IMAGE_SIZE, 32'h0001_0009);
    wr(ADDR_INPUT_CONV_MODE, 32'h03);
    run <= 1'b1;
    for (n = 0; o_entry_ready !== 1'b0 && n < 40; n++) @(negedge i_clk);
    guard(n < 40);
    check(o_conv_mode, 3'h3);
    drain(9, 1'b0);
    run <= 1'b0;
    @(negedge i_clk);
    check(o_conv_mode, 3'h0);
    foreach (prow[i]) begin
      wr(ADDR_TRANSFER_MODE, {30'h0, prow[i].xfer});
      wr(ADDR_IMAGE_SIZE, 32'h0001_0002);
      wr(ADDR_INPUT_CONV_MODE, {24'h0, prow[i].mode});
      run <= 1'b1;
      drain(2, prow[i].sw);
      run <= 1'b0;
    end
    wr(ADDR_INPUT_CONV_MODE, 32'h0B);
    i_rst_n <= 1'b0;
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(ADDR_INPUT_CONV_MODE);
    check(rd_val, 32'h0);
    test_done();
  end
endmodule : input_data_conversion_mode_tb
